// *** verilog/rsc_reset_ctrl.sv ***
// Reset source controller: merges reset sources, times reset processing, records causes
// How it works
// - Seven sources (pin, watchdog, POR, SUPPLY_LEVEL_DETECTOR, opcode, parity, access) cause reset.
// - On release, a one-cycle load strobe presents reset vector 0000H.
// - Low reset pin holds reset; high releases; fast oscillator selected after.
// - Watchdog, opcode, parity, access resets release by themselves after processing.
// - POR and SUPPLY_LEVEL_DETECTOR resets release once the detector reports supply good.
// - Executing opcode FFH raises the illegal-instruction reset.
// - Illegal-instruction reset suppressed while debug emulation is active.
// - During reset crystal stops, its pins are inputs, external clock ignored.
// - Special pin floats in pin or POR reset, pulled up otherwise.
// - All other port pins stay high-impedance during and after reset.
// - Cause register holds separate per-source flags; a read clears them.
// - SUPPLY_LEVEL_DETECTOR reset keeps the detector running; other resets stop it.
// - First pin release after POR: 0.672 ms with SUPPLY_LEVEL_DETECTOR, 0.399 ms without.
// - Later pin releases: 0.531 ms with SUPPLY_LEVEL_DETECTOR, 0.259 ms without.
// - Reset sets port direction register to FFH (input).
// - Reset presets timer count register to FFFFH.
// - Pin reset, POR or cause read clear flags; other resets keep others.
// - Only program counter undefined during reset; all else takes reset values, except the detector enable and, outside pin and POR resets, the cause flags.
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "rsc_params.svh"

module rsc_reset_ctrl #(
   parameter int FIRST_LVD_CYC = `RSC_T_FIRST_LVD_NS / `RSC_CLK_NS,
   parameter int FIRST_NOLVD_CYC = `RSC_T_FIRST_NOLVD_NS / `RSC_CLK_NS,
   parameter int LATER_LVD_CYC = `RSC_T_LATER_LVD_NS / `RSC_CLK_NS,
   parameter int LATER_NOLVD_CYC = `RSC_T_LATER_NOLVD_NS / `RSC_CLK_NS
) (
   // Clock and power-up reset
   input wire logic clk_sys,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Reset sources
   input wire logic reset_pin_n,
   input wire logic por_low,
   input wire logic lvd_low,
   input wire logic wdt_overflow,
   input wire logic parity_err,
   input wire logic bad_access,
   input wire logic opcode_exec,
   input wire logic [7:0] opcode_byte,
   input wire logic debug_mode,
   // Reset and clock control outputs
   output logic int_reset,
   output logic pc_load,
   output logic [15:0] reset_vector_addr,
   output logic cpu_clk_fast_sel,
   output logic crystal_stop,
   output logic osc_pins_input,
   output logic ext_clk_ignore,
   output logic lvd_run,
   output logic periph_hold,
   // Port control outputs
   output logic pullup_pin_pull_en,
   output logic port_all_hiz,
   // Reset-valued registers
   output logic [7:0] osc_wait_value,
   output logic [7:0] port_dir,
   output logic [7:0] port_latch,
   output logic [15:0] timer_count
);

   // ***************************************
   // Pin and detector synchronisers
   // ***************************************
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic pin_n_s;
   logic por_s;
   logic lvd_s;

   // Two stages; only the second stage feeds logic
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync1_q <= 3'h1;
         sync2_q <= 3'h1;
      end else begin
         sync1_q <= {lvd_low, por_low, reset_pin_n};
         sync2_q <= sync1_q;
      end
   end
   assign pin_n_s = sync2_q[0];
   assign por_s = sync2_q[1];
   assign lvd_s = sync2_q[2];

   // ***************************************
   // Source merging
   // ***************************************
   logic illegal_op;
   logic lvl_src;
   logic evt_src;
   logic clr_src;

   // Level sources hold reset; pulse sources start processing directly
   assign illegal_op = opcode_exec && (opcode_byte == `RSC_ILLEGAL_OP)
      && !debug_mode;
   assign lvl_src = !pin_n_s || por_s || lvd_s;
   assign evt_src = wdt_overflow || parity_err || bad_access || illegal_op;
   assign clr_src = !pin_n_s || por_s;

   // ***************************************
   // Sequencer
   // ***************************************
   rsc_pkg::rsc_state_t state_q, state_d;
   rsc_pkg::rsc_kind_t kind_q, kind_d;
   logic [15:0] cnt_q, cnt_d;
   logic [15:0] load_val;
   logic first_q, first_d;
   logic ires_q, ires_d;
   logic pcl_q, pcl_d;
   logic lvd_en_q;

   // Processing time picked per kind; first pin release after POR is longer
   always_comb begin
      if (kind_q == rsc_pkg::RSC_K_PIN && first_q) begin
         load_val = lvd_en_q ? 16'(FIRST_LVD_CYC - 1) : 16'(FIRST_NOLVD_CYC - 1);
      end else begin
         load_val = lvd_en_q ? 16'(LATER_LVD_CYC - 1) : 16'(LATER_NOLVD_CYC - 1);
      end
   end

   // Next state; events are honoured only while running, units are stopped in reset
   always_comb begin
      state_d = state_q;
      kind_d = kind_q;
      cnt_d = cnt_q;
      first_d = first_q;
      pcl_d = 1'b0;
      if (lvl_src) begin
         state_d = rsc_pkg::RSC_HOLD;
         if (por_s) begin
            kind_d = rsc_pkg::RSC_K_POR;
            first_d = 1'b1;
         end else if (!pin_n_s) begin
            kind_d = rsc_pkg::RSC_K_PIN;
         end else begin
            kind_d = rsc_pkg::RSC_K_LVD;
         end
      end else begin
         unique case (state_q)
            rsc_pkg::RSC_RUN: begin
               if (evt_src) begin
                  state_d = rsc_pkg::RSC_PROC;
                  kind_d = rsc_pkg::RSC_K_INT;
                  cnt_d = 16'(LATER_NOLVD_CYC - 1);
                  if (lvd_en_q) begin
                     cnt_d = 16'(LATER_LVD_CYC - 1);
                  end
               end
            end
            rsc_pkg::RSC_HOLD: begin
               state_d = rsc_pkg::RSC_PROC;
               cnt_d = load_val;
            end
            rsc_pkg::RSC_PROC: begin
               if (cnt_q == 16'h0000) begin
                  state_d = rsc_pkg::RSC_RUN;
                  pcl_d = 1'b1;
                  if (kind_q == rsc_pkg::RSC_K_PIN) begin
                     first_d = 1'b0;
                  end
               end else begin
                  cnt_d = cnt_q - 16'h0001;
               end
            end
            default: begin
               state_d = rsc_pkg::RSC_HOLD;
            end
         endcase
      end
      ires_d = (state_d != rsc_pkg::RSC_RUN);
   end

   // Power-up behaves like a POR held in reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= rsc_pkg::RSC_HOLD;
         kind_q <= rsc_pkg::RSC_K_POR;
         cnt_q <= 16'h0000;
         first_q <= 1'b1;
         ires_q <= 1'b1;
         pcl_q <= 1'b0;
      end else begin
         state_q <= state_d;
         kind_q <= kind_d;
         cnt_q <= cnt_d;
         first_q <= first_d;
         ires_q <= ires_d;
         pcl_q <= pcl_d;
      end
   end

   // Reset-time outputs: oscillator, special pin and detector controls follow the internal reset; clock select and port high-impedance are constant
   assign int_reset = ires_q;
   assign pc_load = pcl_q;
   assign reset_vector_addr = `RSC_RESET_VECTOR;
   assign cpu_clk_fast_sel = 1'b1;
   assign crystal_stop = ires_q;
   assign osc_pins_input = ires_q;
   assign ext_clk_ignore = ires_q;
   assign periph_hold = ires_q;
   assign lvd_run = !ires_q || (kind_q == rsc_pkg::RSC_K_LVD);
   assign pullup_pin_pull_en = !(ires_q && (kind_q == rsc_pkg::RSC_K_PIN
      || kind_q == rsc_pkg::RSC_K_POR));
   assign port_all_hiz = 1'b1;

   // ***************************************
   // AHB-Lite slave
   // ***************************************
   logic acc_ok;
   logic wr_q;
   logic [7:0] addr_q;
   logic [31:0] rd_q, rd_d;
   logic [7:0] cause_q, cause_d;
   logic [7:0] oscw_q, oscw_d;
   logic [7:0] pdir_q, pdir_d;
   logic [7:0] plat_q, plat_d;
   logic [15:0] tcnt_q, tcnt_d;
   logic lvd_en_d;
   logic cause_rd;
   logic wr_hit;

   // Zero-wait slave; read data captured in the address phase
   assign acc_ok = hsel && htrans[1] && hready;
   assign cause_rd = acc_ok && !hwrite && (haddr[7:0] == `RSC_OFF_CAUSE) && (haddr[31:8] == 24'h0);
   assign wr_hit = wr_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rd_q;

   // Read mux; unmapped addresses read zero
   always_comb begin
      rd_d = 32'h0000_0000;
      if (acc_ok && !hwrite && haddr[31:8] == 24'h0) begin
         unique case (haddr[7:0])
            `RSC_OFF_CAUSE: rd_d = {24'h0, cause_q};
            `RSC_OFF_CTRL: rd_d = {31'h0, lvd_en_q};
            `RSC_OFF_OSCW: rd_d = {24'h0, oscw_q};
            `RSC_OFF_PDIR: rd_d = {24'h0, pdir_q};
            `RSC_OFF_PLAT: rd_d = {24'h0, plat_q};
            `RSC_OFF_TCNT: rd_d = {16'h0, tcnt_q};
            `RSC_OFF_STAT: rd_d = {27'h0, first_q, kind_q, state_q == rsc_pkg::RSC_PROC, ires_q};
            default: rd_d = 32'h0000_0000;
         endcase
      end
   end

   // Cause flags: clear first, then sets, so a same-cycle event survives
   always_comb begin
      cause_d = cause_q;
      if (clr_src || cause_rd) begin
         cause_d = 8'h00;
      end
      if (state_q == rsc_pkg::RSC_RUN && !lvl_src) begin
         if (illegal_op) cause_d[`RSC_BIT_TRAP] = 1'b1;
         if (wdt_overflow) cause_d[`RSC_BIT_WDT] = 1'b1;
         if (parity_err) cause_d[`RSC_BIT_PAR] = 1'b1;
         if (bad_access) cause_d[`RSC_BIT_ACC] = 1'b1;
      end
      if (lvd_s && pin_n_s && !por_s) begin
         cause_d[`RSC_BIT_LVD] = 1'b1;
      end
   end

   // Register writes in the data phase; internal reset overrides all but the control write
   always_comb begin
      oscw_d = oscw_q;
      pdir_d = pdir_q;
      plat_d = plat_q;
      tcnt_d = tcnt_q;
      lvd_en_d = lvd_en_q;
      if (wr_hit) begin
         unique case (addr_q)
            `RSC_OFF_CTRL: lvd_en_d = hwdata[0];
            `RSC_OFF_OSCW: oscw_d = hwdata[7:0];
            `RSC_OFF_PDIR: pdir_d = hwdata[7:0];
            `RSC_OFF_PLAT: plat_d = hwdata[7:0];
            `RSC_OFF_TCNT: tcnt_d = hwdata[15:0];
            default: ;
         endcase
      end
      // Follows the next internal reset, so reset values stand from its first cycle
      if (ires_d) begin
         oscw_d = `RSC_RST_OSCW;
         pdir_d = `RSC_RST_PDIR;
         plat_d = `RSC_RST_PLAT;
         tcnt_d = `RSC_RST_TCNT;
      end
   end

   // Bus state and registers; voltage detect enable survives internal resets
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_q <= 1'b0;
         addr_q <= 8'h00;
         rd_q <= 32'h0000_0000;
         cause_q <= 8'h00;
         oscw_q <= `RSC_RST_OSCW;
         pdir_q <= `RSC_RST_PDIR;
         plat_q <= `RSC_RST_PLAT;
         tcnt_q <= `RSC_RST_TCNT;
         lvd_en_q <= `RSC_RST_CTRL;
      end else begin
         wr_q <= acc_ok && hwrite && (haddr[31:8] == 24'h0);
         addr_q <= haddr[7:0];
         rd_q <= rd_d;
         cause_q <= cause_d;
         oscw_q <= oscw_d;
         pdir_q <= pdir_d;
         plat_q <= plat_d;
         tcnt_q <= tcnt_d;
         lvd_en_q <= lvd_en_d;
      end
   end

   assign osc_wait_value = oscw_q;
   assign port_dir = pdir_q;
   assign port_latch = plat_q;
   assign timer_count = tcnt_q;

   // ***************************************
   // Assertions
   // ***************************************
   logic [15:0] proc_len_q;
   logic [15:0] loaded_q;

   // Helper: length of the processing interval against the value loaded
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         proc_len_q <= 16'h0000;
         loaded_q <= 16'h0000;
      end else if (state_q != rsc_pkg::RSC_PROC) begin
         proc_len_q <= 16'h0000;
         loaded_q <= cnt_d;
      end else begin
         proc_len_q <= proc_len_q + 16'h0001;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   property p_evt_reset;
      state_q == rsc_pkg::RSC_RUN && !lvl_src && evt_src |=> int_reset ##1 int_reset;
   endproperty
   a_evt_reset: assert property (p_evt_reset) else $error("event did not start reset");

   property p_pin_hold;
      !pin_n_s |=> int_reset && kind_q == rsc_pkg::RSC_K_PIN || por_s;
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("low pin did not hold reset");

   property p_trap_flag;
      state_q == rsc_pkg::RSC_RUN && !lvl_src && opcode_exec && opcode_byte == 8'hFF
         && !debug_mode |=> cause_q[7] && int_reset;
   endproperty
   a_trap_flag: assert property (p_trap_flag) else $error("FFH did not trap");

   property p_dbg_quiet;
      state_q == rsc_pkg::RSC_RUN && !lvl_src && debug_mode && !wdt_overflow && !parity_err
         && !bad_access |=> !int_reset && !$rose(cause_q[7]);
   endproperty
   a_dbg_quiet: assert property (p_dbg_quiet) else $error("trap reset under debug");

   property p_float;
      int_reset && (kind_q == rsc_pkg::RSC_K_PIN || kind_q == rsc_pkg::RSC_K_POR)
         |-> !pullup_pin_pull_en && !lvd_run;
   endproperty
   a_float: assert property (p_float) else $error("special pin not floating");

   property p_lvd_live;
      int_reset && kind_q == rsc_pkg::RSC_K_LVD |-> lvd_run && pullup_pin_pull_en;
   endproperty
   a_lvd_live: assert property (p_lvd_live) else $error("detector stopped in own reset");

   property p_vector;
      pc_load |-> !int_reset && $past(int_reset) && reset_vector_addr == 16'h0000;
   endproperty
   a_vector: assert property (p_vector) else $error("bad release strobe");

   property p_proc_len;
      pc_load |-> $past(proc_len_q) == $past(loaded_q);
   endproperty
   a_proc_len: assert property (p_proc_len) else $error("processing length wrong");

   property p_reset_vals;
      $fell(int_reset) |-> osc_wait_value == 8'h07 && port_dir == 8'hFF && port_latch == 8'h00
         && timer_count == 16'hFFFF;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

   property p_read_clr;
      cause_rd && !evt_src && !lvd_s |=> cause_q == 8'h00;
   endproperty
   a_read_clr: assert property (p_read_clr) else $error("read did not clear causes");

   c_pin_release: cover property (!pin_n_s ##[1:1000] pc_load);
   c_wdt_reset: cover property (state_q == rsc_pkg::RSC_RUN && wdt_overflow ##1 int_reset);
   c_lvd_reset: cover property (int_reset && kind_q == rsc_pkg::RSC_K_LVD);

endmodule

// *** verilog/rsc_params.svh ***
// Constants of the reset source controller: offsets, fields, reset values, timings
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// ***************************************
// Register byte offsets
// ***************************************
`define RSC_OFF_CAUSE 8'h00
`define RSC_OFF_CTRL 8'h04
`define RSC_OFF_OSCW 8'h08
`define RSC_OFF_PDIR 8'h0C
`define RSC_OFF_PLAT 8'h10
`define RSC_OFF_TCNT 8'h14
`define RSC_OFF_STAT 8'h18

// ***************************************
// Cause register bit positions
// ***************************************
`define RSC_BIT_TRAP 7
`define RSC_BIT_WDT 4
`define RSC_BIT_PAR 2
`define RSC_BIT_ACC 1
`define RSC_BIT_LVD 0

// ***************************************
// Reset values, illegal opcode and reset vector
// ***************************************
`define RSC_RST_OSCW 8'h07
`define RSC_RST_PDIR 8'hFF
`define RSC_RST_PLAT 8'h00
`define RSC_RST_TCNT 16'hFFFF
`define RSC_RST_CTRL 1'b1
`define RSC_ILLEGAL_OP 8'hFF
`define RSC_RESET_VECTOR 16'h0000

// ***************************************
// Reset processing times (ns) and clock period
// ***************************************
`define RSC_CLK_NS 20
`define RSC_T_FIRST_LVD_NS 672000
`define RSC_T_FIRST_NOLVD_NS 399000
`define RSC_T_LATER_LVD_NS 531000
`define RSC_T_LATER_NOLVD_NS 259000

`endif

// *** verilog/rsc_pkg.sv ***
// Types of the reset source controller
package rsc_pkg;

   // Sequencer states
   typedef enum logic [1:0] {
      RSC_RUN = 2'b00,
      RSC_HOLD = 2'b01,
      RSC_PROC = 2'b10
   } rsc_state_t;

   // Kind of the reset being processed
   typedef enum logic [1:0] {
      RSC_K_PIN = 2'b00,
      RSC_K_POR = 2'b01,
      RSC_K_LVD = 2'b10,
      RSC_K_INT = 2'b11
   } rsc_kind_t;

endpackage

// *** tb/rsc_src_model.sv ***
// Partner model: external reset driver and on-chip fault detectors
`timescale 1ns/1ps

module rsc_src_model (
   // Clock
   input wire logic clk_sys,
   // Reset sources toward the controller
   output logic reset_pin_n,
   output logic por_low,
   output logic lvd_low,
   output logic wdt_overflow,
   output logic parity_err,
   output logic bad_access,
   output logic opcode_exec,
   output logic [7:0] opcode_byte,
   output logic debug_mode
);
   // Minimum pin low time of 10 us, in 20 ns clocks
   localparam int PIN_LOW_CYC = 500;

   // ****************************************
   // Idle levels
   // ****************************************
   initial begin
      reset_pin_n = 1'h1;
      {por_low, lvd_low, wdt_overflow, parity_err, bad_access} = 5'h00;
      {opcode_exec, debug_mode} = 2'h0;
      opcode_byte = 8'h00;
   end

   // Pin held low for the full minimum, then released to the pulled-up level
   task automatic pin_reset();
      @(posedge clk_sys);
      reset_pin_n <= 1'h0;
      repeat (PIN_LOW_CYC) @(posedge clk_sys);
      reset_pin_n <= 1'h1;
   endtask

   // One-cycle fault pulse: 0 watchdog, 1 parity, 2 bad access
   task automatic fault(input int src);
      @(posedge clk_sys);
      wdt_overflow <= (src == 0);
      parity_err <= (src == 1);
      bad_access <= (src == 2);
      @(posedge clk_sys);
      {wdt_overflow, parity_err, bad_access} <= 3'h0;
   endtask

   // Executed opcode; the byte toggles afterwards so a stale value is never reused
   task automatic exec(input logic [7:0] op, input logic dbg);
      @(posedge clk_sys);
      opcode_exec <= 1'h1;
      opcode_byte <= op;
      debug_mode <= dbg;
      @(posedge clk_sys);
      opcode_exec <= 1'h0;
      opcode_byte <= ~op;
   endtask

   // Supply below a detector threshold for a number of cycles
   task automatic supply(input logic por, input logic supply_level_detector, input int cyc);
      @(posedge clk_sys);
      por_low <= por;
      lvd_low <= supply_level_detector;
      repeat (cyc) @(posedge clk_sys);
      {por_low, lvd_low} <= 2'h0;
   endtask
endmodule

// *** tb/rsc_reset_ctrl_test.sv ***
// Self-checking testbench of the reset source controller
`timescale 1ns/1ps
`include "rsc_params.svh"

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
   $display("Error %0t: got %0h expected %0h", $time, (a), (b)); end end

module rsc_reset_ctrl_test;
   // Shortened processing counts
   localparam int FL = 8, FN = 6, LL = 5, LN = 3;
   logic clk_sys = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, int_reset, pc_load, cpu_clk_fast_sel, crystal_stop;
   logic osc_pins_input, ext_clk_ignore, lvd_run, periph_hold, pullup_pin_pull_en;
   logic port_all_hiz, reset_pin_n, por_low, lvd_low, wdt_overflow, parity_err;
   logic bad_access, opcode_exec, debug_mode;
   logic [7:0] opcode_byte, osc_wait_value, port_dir, port_latch;
   logic [15:0] reset_vector_addr, timer_count;
   int error_cnt = 0, checked = 0, cyc_cnt = 0, n1, n2, n3, n4;

   rsc_reset_ctrl #(.FIRST_LVD_CYC(FL), .FIRST_NOLVD_CYC(FN), .LATER_LVD_CYC(LL),
      .LATER_NOLVD_CYC(LN)) dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .reset_pin_n(reset_pin_n), .por_low(por_low), .lvd_low(lvd_low),
      .wdt_overflow(wdt_overflow), .parity_err(parity_err), .bad_access(bad_access),
      .opcode_exec(opcode_exec), .opcode_byte(opcode_byte), .debug_mode(debug_mode),
      .int_reset(int_reset), .pc_load(pc_load), .reset_vector_addr(reset_vector_addr),
      .cpu_clk_fast_sel(cpu_clk_fast_sel), .crystal_stop(crystal_stop),
      .osc_pins_input(osc_pins_input), .ext_clk_ignore(ext_clk_ignore),
      .lvd_run(lvd_run), .periph_hold(periph_hold),
      .pullup_pin_pull_en(pullup_pin_pull_en), .port_all_hiz(port_all_hiz),
      .osc_wait_value(osc_wait_value), .port_dir(port_dir), .port_latch(port_latch),
      .timer_count(timer_count));

   rsc_src_model src (.clk_sys(clk_sys), .reset_pin_n(reset_pin_n), .por_low(por_low),
      .lvd_low(lvd_low), .wdt_overflow(wdt_overflow), .parity_err(parity_err),
      .bad_access(bad_access), .opcode_exec(opcode_exec), .opcode_byte(opcode_byte),
      .debug_mode(debug_mode));

   // ****************************************
   // Clock, hang guard and closing report
   // ****************************************
   always #10 clk_sys = ~clk_sys;

   // Ceiling well above the roughly 2300 cycles the tests need
   always @(posedge clk_sys) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ****************************************
   // Bus and helper tasks
   // ****************************************
   // Single AHB-Lite word transfer; read data taken at the data phase edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      do @(posedge clk_sys); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'h1);
      q = hrdata;
      `CHK(hresp, 1'h0)
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'h0, a, 32'h0);
      `CHK(q, exp)
   endtask

   // Values every kind of reset must show while it is active
   task automatic chk_in(input logic pull, input logic supply_level_detector);
      `CHK(int_reset, 1'h1)
      `CHK({crystal_stop, osc_pins_input, ext_clk_ignore}, 3'h7)
      `CHK(periph_hold, 1'h1)
      `CHK(pullup_pin_pull_en, pull)
      `CHK(lvd_run, supply_level_detector)
      `CHK(port_all_hiz, 1'h1)
      `CHK({osc_wait_value, port_dir, port_latch}, 24'h07FF00)
      `CHK(timer_count, 16'hFFFF)
   endtask

   // Cycles until the vector load strobe, which must last one cycle only
   task automatic wait_pc(output int n);
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pc_load !== 1'h1 && n < 3000);
      `CHK(pc_load, 1'h1)
      `CHK(reset_vector_addr, 16'h0000)
      `CHK(cpu_clk_fast_sel, 1'h1)
      @(posedge clk_sys);
      `CHK({pc_load, int_reset}, 2'h0)
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   // Reset values, unmapped place, a latch write that a later reset must undo
   task automatic t_regs();
      rd(`RSC_OFF_OSCW, 32'h07);
      rd(`RSC_OFF_PDIR, 32'hFF);
      rd(`RSC_OFF_PLAT, 32'h00);
      rd(`RSC_OFF_TCNT, 32'hFFFF);
      rd(`RSC_OFF_CTRL, 32'h1);
      // Running, first pin release still pending, last kind power-on
      rd(`RSC_OFF_STAT, 32'h14);
      rd(8'h40, 32'h0);
      ahb(1'h1, `RSC_OFF_PLAT, 32'h5A);
      rd(`RSC_OFF_PLAT, 32'h5A);
      $display("Test regs done");
   endtask

   // Self-releasing fault resets, cause flags, read clear
   task automatic t_faults();
      logic [7:0] bits [3] = '{8'h10, 8'h04, 8'h02};
      for (int s = 0; s < 3; s++) begin
         ahb(1'h1, `RSC_OFF_TCNT, 32'h1234);
         src.fault(s);
         @(posedge clk_sys);
         chk_in(1'h1, 1'h0);
         wait_pc(n1);
         rd(`RSC_OFF_CAUSE, {24'h0, bits[s]});
         rd(`RSC_OFF_CAUSE, 32'h0);
         rd(`RSC_OFF_TCNT, 32'hFFFF);
      end
      $display("Test faults done");
   endtask

   // All-ones opcode resets unless emulating; other opcodes never do
   task automatic t_opcode();
      src.exec(8'hFF, 1'h1);
      repeat (3) @(posedge clk_sys);
      `CHK(int_reset, 1'h0)
      src.exec(8'hFE, 1'h0);
      repeat (3) @(posedge clk_sys);
      `CHK(int_reset, 1'h0)
      src.exec(8'hFF, 1'h0);
      @(posedge clk_sys);
      chk_in(1'h1, 1'h0);
      wait_pc(n1);
      rd(`RSC_OFF_CAUSE, 32'h80);
      $display("Test opcode done");
   endtask

   // Detector resets: the voltage one keeps its detector running and sets its flag
   task automatic t_supply();
      fork
         src.supply(1'h0, 1'h1, 30);
         begin
            repeat (10) @(posedge clk_sys);
            chk_in(1'h1, 1'h1);
         end
      join
      wait_pc(n1);
      rd(`RSC_OFF_CAUSE, 32'h01);
      src.fault(1);
      wait_pc(n1);
      fork
         src.supply(1'h1, 1'h0, 30);
         begin
            repeat (10) @(posedge clk_sys);
            chk_in(1'h0, 1'h0);
         end
      join
      wait_pc(n1);
      rd(`RSC_OFF_CAUSE, 32'h0);
      $display("Test supply done");
   endtask

   // Pin resets; processing times compared by difference to cancel the sync delay
   task automatic pin(output int n);
      fork
         src.pin_reset();
         begin
            repeat (100) @(posedge clk_sys);
            chk_in(1'h0, 1'h0);
         end
      join
      wait_pc(n);
   endtask

   task automatic t_pin();
      src.fault(0);
      wait_pc(n1);
      pin(n1);
      rd(`RSC_OFF_CAUSE, 32'h0);
      pin(n2);
      `CHK(n1 - n2, FL - LL)
      ahb(1'h1, `RSC_OFF_CTRL, 32'h0);
      pin(n3);
      `CHK(n2 - n3, LL - LN)
      src.supply(1'h1, 1'h0, 30);
      wait_pc(n4);
      pin(n4);
      `CHK(n4 - n3, FN - LN)
      ahb(1'h1, `RSC_OFF_CTRL, 32'h1);
      $display("Test pin done");
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'h0;
      wait_pc(n1);
      t_regs();
      t_faults();
      t_opcode();
      t_supply();
      t_pin();
      end_of_test();
   end
endmodule
